// *** iobdc_pkg.sv ***
// package of constants and a bit-index helper for the io bus control-line block
package iobdc_pkg;
    // ========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int CLEAR_PULSE_NS = 250;
    localparam int SYNC_PULSE_NS = 250;
    localparam int SYNC_PERIOD_NS = 1000;
    // a pulse width is a least time: round up
    localparam int CLEAR_CYCLES =
        (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_HIGH_CYCLES =
        (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // the sync period is a rate: exact division
    localparam int SYNC_PERIOD_CYCLES = SYNC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // ========================================================
    // instruction and bus geometry
    localparam int DATA_W = 18;
    localparam int INSTR_SD_LOW_BIT = 12;
    localparam int INSTR_SD_HIGH_BIT = 13;
    localparam int INSTR_PULSE1_BIT = 17;
    localparam int ADDR_BIT_SKIP = 1;
    localparam int ADDR_BIT_WRITE = 2;
    localparam logic [DATA_W-1:0] TRAP_ADDR = 18'h00000;
    localparam logic [DATA_W-1:0] TRAP_FETCH_ADDR = 18'h00001;
    localparam logic [DATA_W-1:0] STATUS_RESET = 18'h00000;
    // ========================================================
    // bit index within the 18-bit word, bit 0 is msb as printed
    function automatic int iobdc_bit(input int printed);
        return DATA_W - 1 - printed;
    endfunction
endpackage

// *** iobdc_bus_if.sv ***
// interface carrying the control lines between processor and controller
`timescale 1ns/1ps
interface iobdc_bus_if;
    logic busPowerClear;
    logic busSync;
    logic busRun;
    logic readStatus;
    logic subdeviceSelectLow;
    logic subdeviceSelectHigh;
    logic firstIoPulse;
    logic wordCountOverflow;
    logic singleCycleBreak;
    logic [17:0] statusData;
    logic programInterruptRequest;
    logic inputWordRequest;
    logic outputWordRequest;
    logic singleCycleRequest;
    logic skipConditionRequest;
    logic addressIncrementInhibit;
    logic channelRequest;
    logic priorityInterruptRequest;

    modport processor (
        output busPowerClear, busSync, busRun, readStatus,
        output subdeviceSelectLow, subdeviceSelectHigh, firstIoPulse,
        output wordCountOverflow, singleCycleBreak,
        input statusData, programInterruptRequest, inputWordRequest,
        input outputWordRequest, singleCycleRequest,
        input skipConditionRequest, addressIncrementInhibit,
        input channelRequest, priorityInterruptRequest
    );
    modport controller (
        input busPowerClear, busSync, busRun, readStatus,
        input subdeviceSelectLow, subdeviceSelectHigh, firstIoPulse,
        input wordCountOverflow, singleCycleBreak,
        output statusData, programInterruptRequest, inputWordRequest,
        output outputWordRequest, singleCycleRequest,
        output skipConditionRequest, addressIncrementInhibit,
        output channelRequest, priorityInterruptRequest
    );
endinterface

// *** iobdc_processor.sv ***
// processor end: drives clear, sync, run, strobes; samples requests
`timescale 1ns/1ps
module iobdc_processor
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    iobdc_bus_if.processor bus,
    input wire logic clearRequest,
    input wire logic runEnable,
    input wire logic instrValid,
    input wire logic [iobdc_pkg::DATA_W-1:0] instrWord,
    input wire logic readStatusInstruction,
    input wire logic singleCycleBreakIn,
    input wire logic countBecameZero,
    output logic [iobdc_pkg::DATA_W-1:0] statusCapture,
    output logic statusValid,
    output logic skipTaken,
    output logic interruptTrap,
    output logic [iobdc_pkg::DATA_W-1:0] trapAddress,
    output logic [iobdc_pkg::DATA_W-1:0] trapFetchAddress,
    output logic transferRequested,
    output logic transferIsInput,
    output logic incrementInhibited
);
    import iobdc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] syncCnt;
        logic [CNT_W-1:0] clearCnt;
        logic run;
        logic statusStrobe;
        logic sdLow;
        logic sdHigh;
        logic pulse1;
        logic overflow;
        logic [DATA_W-1:0] status;
        logic statusValid;
        logic skip;
        logic trap;
        logic xferReq;
        logic xferIn;
        logic incInhibit;
    } iobdc_proc_t;

    iobdc_proc_t cur;
    iobdc_proc_t next_cur;

    // ========================================================
    // next state
    always_comb
    begin
        next_cur = cur;
        // 1 MHz sync, high for the first 32 cycles (256 ns) of each microsecond
        if (cur.syncCnt == CNT_W'(SYNC_PERIOD_CYCLES - 1))
            next_cur.syncCnt = '0;
        else
            next_cur.syncCnt = cur.syncCnt + 8'h01;
        // clear pulse restarts on a request or on any change of run
        if (clearRequest || (cur.run && !runEnable)
            || (!cur.run && runEnable))
            next_cur.clearCnt = CNT_W'(CLEAR_CYCLES);
        else if (cur.clearCnt != '0)
            next_cur.clearCnt = cur.clearCnt - 8'h01;
        next_cur.run = runEnable;
        next_cur.statusStrobe = readStatusInstruction;
        next_cur.pulse1 = 1'b0;
        if (instrValid)
        begin
            // subdevice lines come from the instruction word
            next_cur.sdLow = instrWord[iobdc_bit(INSTR_SD_LOW_BIT)];
            next_cur.sdHigh = instrWord[iobdc_bit(INSTR_SD_HIGH_BIT)];
            next_cur.pulse1 = instrWord[iobdc_bit(INSTR_PULSE1_BIT)];
        end
        next_cur.overflow = countBecameZero;
        // status gated onto the data lines during the strobe
        next_cur.statusValid = cur.statusStrobe;
        if (cur.statusStrobe)
            next_cur.status = bus.statusData;
        // skip seen while first pulse is out, not in a break
        next_cur.skip = cur.pulse1 && !singleCycleBreakIn
            && bus.skipConditionRequest;
        next_cur.trap = bus.programInterruptRequest && cur.run;
        next_cur.xferReq = bus.singleCycleRequest;
        next_cur.xferIn = bus.singleCycleRequest
            && bus.channelRequest;
        next_cur.incInhibit = bus.addressIncrementInhibit;
    end

    // ========================================================
    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
            cur <= '0;
        else if (clkEn)
            cur <= next_cur;
    end

    // ========================================================
    // bus outputs
    assign bus.busSync = cur.syncCnt < CNT_W'(SYNC_HIGH_CYCLES);
    assign bus.busPowerClear = cur.clearCnt != '0;
    assign bus.busRun = cur.run;
    assign bus.readStatus = cur.statusStrobe;
    assign bus.subdeviceSelectLow = cur.sdLow;
    assign bus.subdeviceSelectHigh = cur.sdHigh;
    assign bus.firstIoPulse = cur.pulse1;
    assign bus.wordCountOverflow = cur.overflow;
    assign bus.singleCycleBreak = singleCycleBreakIn;

    // user-side outputs
    assign statusCapture = cur.status;
    assign statusValid = cur.statusValid;
    assign skipTaken = cur.skip; // pc advances by one
    assign interruptTrap = cur.trap;
    assign trapAddress = TRAP_ADDR;
    assign trapFetchAddress = TRAP_FETCH_ADDR;
    assign transferRequested = cur.xferReq;
    assign transferIsInput = cur.xferIn;
    assign incrementInhibited = cur.incInhibit;
endmodule

// *** iobdc_controller.sv ***
// controller end of the io bus control lines
`timescale 1ns/1ps
module iobdc_controller
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    iobdc_bus_if.controller bus,
    input wire logic [iobdc_pkg::DATA_W-1:0] deviceStatus,
    input wire logic wantInterrupt,
    input wire logic skipTest,
    input wire logic wantInputWord,
    input wire logic wantOutputWord,
    input wire logic wantSingleCycle,
    input wire logic singleCycleInput,
    input wire logic [iobdc_pkg::DATA_W-1:0] breakAddress,
    input wire logic wantChannel,
    input wire logic wantPriorityInterrupt,
    input wire logic holdAddress,
    output logic [1:0] modeSelect,
    output logic transferDone,
    output logic deviceEnabled
);
    import iobdc_pkg::*;

    // mode decoded from the two subdevice lines
    function automatic logic [1:0] iobdc_mode(input logic hi,
        input logic lo);
        return {hi, lo};
    endfunction

    typedef struct packed {
        logic syncSeen;
        logic chanReq;
        logic prioReq;
        logic [1:0] mode;
        logic done;
        logic enabled;
    } iobdc_ctrl_t;

    iobdc_ctrl_t cur;
    iobdc_ctrl_t next_cur;
    logic syncEdge;
    logic active;

    // ========================================================
    // next state
    assign syncEdge = bus.busSync && !cur.syncSeen;
    // a stopped processor disables the controller
    assign active = cur.enabled && bus.busRun;

    always_comb
    begin
        next_cur = cur;
        next_cur.syncSeen = bus.busSync;
        next_cur.enabled = bus.busRun;
        // requests only change on the rising edge of sync, or on a clear
        if (syncEdge)
        begin
            next_cur.chanReq = active && (wantChannel
                || (wantSingleCycle && singleCycleInput));
            next_cur.prioReq = active && wantPriorityInterrupt;
        end
        if (bus.firstIoPulse)
            next_cur.mode = iobdc_mode(bus.subdeviceSelectHigh,
                bus.subdeviceSelectLow);
        // overflow ends the transfer; sticky until next clear
        if (bus.wordCountOverflow)
            next_cur.done = 1'b1;
        // clear wins, so all registers go to initial state
        if (bus.busPowerClear)
            next_cur = '0;
    end

    // ========================================================
    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
            cur <= '0;
        else if (clkEn)
            cur <= next_cur;
    end

    // ========================================================
    // bus outputs; skip and output-word request lines double as address in breaks
    assign bus.statusData = bus.readStatus ? deviceStatus
        : STATUS_RESET;
    assign bus.programInterruptRequest = active && wantInterrupt;
    assign bus.inputWordRequest = active && wantInputWord;
    assign bus.singleCycleRequest = active && wantSingleCycle;
    assign bus.channelRequest = cur.chanReq;
    assign bus.priorityInterruptRequest = cur.prioReq;
    // skip is answered only to the first pulse, never in a break
    assign bus.skipConditionRequest = bus.singleCycleBreak
        ? breakAddress[iobdc_bit(ADDR_BIT_SKIP)]
        : (active && bus.firstIoPulse && skipTest);
    assign bus.outputWordRequest = bus.singleCycleBreak
        ? breakAddress[iobdc_bit(ADDR_BIT_WRITE)]
        : (active && wantOutputWord);
    assign bus.addressIncrementInhibit = active && holdAddress;

    assign modeSelect = cur.mode;
    assign transferDone = cur.done;
    assign deviceEnabled = cur.enabled;
endmodule

// *** iobdc_properties.sv ***
// concurrent checks on the io bus control lines
`timescale 1ns/1ps
module iobdc_properties (
    input wire logic mclk,
    input wire logic srst,
    input wire logic busPowerClear,
    input wire logic busSync,
    input wire logic busRun,
    input wire logic readStatus,
    input wire logic firstIoPulse,
    input wire logic singleCycleBreak,
    input wire logic [17:0] statusData,
    input wire logic programInterruptRequest,
    input wire logic inputWordRequest,
    input wire logic singleCycleRequest,
    input wire logic addressIncrementInhibit,
    input wire logic skipConditionRequest,
    input wire logic channelRequest,
    input wire logic priorityInterruptRequest
);
    // ========================================================
    // properties, all on mclk
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    clear_width_a: assert property (
        $rose(busPowerClear) |-> ##32 $fell(busPowerClear))
        else $error("clear pulse width wrong");
    sync_width_a: assert property (
        $rose(busSync) |-> ##32 $fell(busSync))
        else $error("sync pulse width wrong");
    sync_period_a: assert property (
        $rose(busSync) |-> ##125 $rose(busSync))
        else $error("sync period wrong");
    clear_resets_a: assert property (
        $fell(busPowerClear) |-> !(channelRequest
        || priorityInterruptRequest || programInterruptRequest))
        else $error("request survived clear");
    // registered requests move only on a sync rise, clear or run loss
    chan_on_sync_a: assert property (
        $changed(channelRequest) |->
        ($past(busSync) && !$past(busSync, 2)) || $past(busPowerClear)
        || !busRun || !$past(busRun))
        else $error("channel off sync");
    prio_on_sync_a: assert property (
        $changed(priorityInterruptRequest) |->
        ($past(busSync) && !$past(busSync, 2)) || $past(busPowerClear)
        || !busRun || !$past(busRun))
        else $error("priority off sync");
    idle_when_stopped_a: assert property (
        !busRun && !$past(busRun) |-> !(programInterruptRequest
        || inputWordRequest || singleCycleRequest
        || addressIncrementInhibit))
        else $error("request while stopped");
    status_gated_a: assert property (
        !readStatus |-> statusData == 18'h00000)
        else $error("status driven without strobe");
    skip_in_pulse_a: assert property (
        skipConditionRequest && !singleCycleBreak |-> firstIoPulse)
        else $error("skip outside first pulse");
    cover property ($rose(busSync));
    cover property (skipConditionRequest && firstIoPulse);
    cover property (readStatus && statusData != 18'h00000);
    cover property ($rose(channelRequest));
endmodule

// *** tb_top.sv ***
// self-checking bench joining both ends of the io bus
`timescale 1ns/1ps
module tb_top;
    import iobdc_pkg::*;
    logic mclk, srst, clearRequest, runEnable, instrValid;
    logic readStatusInstruction;
    logic singleCycleBreakIn, countBecameZero, wantInterrupt, skipTest;
    logic wantInputWord, wantOutputWord, wantSingleCycle, singleCycleInput;
    logic wantChannel, wantPriorityInterrupt, holdAddress, statusValid;
    logic skipTaken, interruptTrap, transferRequested, transferIsInput;
    logic incrementInhibited, transferDone, deviceEnabled;
    logic clkEn = 1'b1;
    logic [17:0] instrWord, deviceStatus, breakAddress, statusCapture;
    logic [17:0] trapAddress, trapFetchAddress;
    logic [1:0] modeSelect;
    int errors = 0;
    int cmp_count = 0;
    int hi, lo;
    iobdc_bus_if bus ();
    iobdc_processor u_iobdc_processor (.mclk(mclk), .srst(srst),
        .clkEn(clkEn), .bus(bus), .clearRequest(clearRequest),
        .runEnable(runEnable), .instrValid(instrValid),
        .instrWord(instrWord),
        .readStatusInstruction(readStatusInstruction),
        .singleCycleBreakIn(singleCycleBreakIn),
        .countBecameZero(countBecameZero),
        .statusCapture(statusCapture), .statusValid(statusValid),
        .skipTaken(skipTaken), .interruptTrap(interruptTrap),
        .trapAddress(trapAddress), .trapFetchAddress(trapFetchAddress),
        .transferRequested(transferRequested),
        .transferIsInput(transferIsInput),
        .incrementInhibited(incrementInhibited));
    iobdc_controller u_iobdc_controller (.mclk(mclk), .srst(srst),
        .clkEn(clkEn), .bus(bus), .deviceStatus(deviceStatus),
        .wantInterrupt(wantInterrupt), .skipTest(skipTest),
        .wantInputWord(wantInputWord), .wantOutputWord(wantOutputWord),
        .wantSingleCycle(wantSingleCycle),
        .singleCycleInput(singleCycleInput), .breakAddress(breakAddress),
        .wantChannel(wantChannel),
        .wantPriorityInterrupt(wantPriorityInterrupt),
        .holdAddress(holdAddress), .modeSelect(modeSelect),
        .transferDone(transferDone), .deviceEnabled(deviceEnabled));
    iobdc_properties u_iobdc_properties (.mclk(mclk), .srst(srst),
        .busPowerClear(bus.busPowerClear), .busSync(bus.busSync),
        .busRun(bus.busRun), .readStatus(bus.readStatus),
        .firstIoPulse(bus.firstIoPulse),
        .singleCycleBreak(bus.singleCycleBreak), .statusData(bus.statusData),
        .programInterruptRequest(bus.programInterruptRequest),
        .inputWordRequest(bus.inputWordRequest),
        .singleCycleRequest(bus.singleCycleRequest),
        .addressIncrementInhibit(bus.addressIncrementInhibit),
        .skipConditionRequest(bus.skipConditionRequest),
        .channelRequest(bus.channelRequest),
        .priorityInterruptRequest(bus.priorityInterruptRequest));
    // ========================================================
    // clock, helpers
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // inputs change 1 ns after the edge so no race with the design
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one transfer instruction, valid for a single cycle
    task automatic send_instr(input logic [17:0] w);
        instrWord = w;
        instrValid = 1'b1;
        tick(1);
        instrValid = 1'b0;
    endtask
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input bit s);
        return s ? bus.busSync : bus.busPowerClear;
    endfunction
    // bounded measure of the next high pulse and the gap after it
    task automatic pulse(input bit s, output int h, output int l);
        h = 0;
        l = 0;
        for (int i = 0; i < 400 && sig(s) !== 1'b1; i++)
            tick(1);
        while (sig(s) === 1'b1 && h < 400)
        begin
            h++;
            tick(1);
        end
        while (sig(s) !== 1'b1 && l < 400)
        begin
            l++;
            tick(1);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ========================================================
    // tests
    initial
    begin
        {clearRequest, runEnable, instrValid, readStatusInstruction} = '0;
        {singleCycleBreakIn, countBecameZero, wantInterrupt, skipTest} = '0;
        {wantInputWord, wantOutputWord, wantSingleCycle} = '0;
        {singleCycleInput, wantChannel, wantPriorityInterrupt} = '0;
        {holdAddress, instrWord, deviceStatus, breakAddress} = '0;
        srst = 1'b1;
        tick(3);
        srst = 1'b0;
        pulse(1'b1, hi, lo);
        check(18'(hi), 18'h00020);
        check(18'(hi + lo), 18'h0007D);
        $display("sync test done");
        runEnable = 1'b1;
        pulse(1'b0, hi, lo);
        check(18'(hi), 18'h00020);
        check(18'(bus.busRun), 18'h00001);
        check(18'(deviceEnabled), 18'h00001);
        $display("run test done");
        // every mode code, skip test true on odd codes
        for (int m = 0; m < 4; m++)
        begin
            skipTest = m[0];
            send_instr({12'h000, m[0], m[1], 3'h0, 1'b1});
            check(18'(bus.skipConditionRequest), 18'(m[0]));
            tick(1);
            check(18'(skipTaken), 18'(m[0]));
            check(18'(modeSelect), 18'(m[1:0]));
            tick(2);
        end
        $display("skip test done");
        deviceStatus = 18'h2A5C3;
        check(bus.statusData, 18'h00000);
        readStatusInstruction = 1'b1;
        tick(2);
        check(bus.statusData, 18'h2A5C3);
        check(statusCapture, 18'h2A5C3);
        check(18'(statusValid), 18'h00001);
        readStatusInstruction = 1'b0;
        wantInterrupt = 1'b1;
        tick(2);
        check(18'(interruptTrap), 18'h00001);
        check(trapAddress, 18'h00000);
        check(trapFetchAddress, 18'h00001);
        wantInterrupt = 1'b0;
        $display("status test done");
        // single cycle with and without a channel request
        for (int c = 0; c < 2; c++)
        begin
            {wantInputWord, wantOutputWord, holdAddress} = 3'b111;
            {wantSingleCycle, wantPriorityInterrupt} = 2'b11;
            {wantChannel, singleCycleInput} = {2{c[0]}};
            tick(130);
            check(18'(bus.inputWordRequest), 18'h00001);
            check(18'(bus.outputWordRequest), 18'h00001);
            check(18'(incrementInhibited), 18'h00001);
            check(18'(bus.priorityInterruptRequest), 18'h00001);
            check(18'(bus.channelRequest), 18'(c[0]));
            check(18'(transferRequested), 18'h00001);
            check(18'(transferIsInput), 18'(c[0]));
        end
        {wantInputWord, wantOutputWord, holdAddress, wantSingleCycle} = '0;
        singleCycleBreakIn = 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            breakAddress = b ? 18'h08000 : 18'h10000;
            tick(1);
            check(18'(bus.skipConditionRequest), 18'(b == 0));
            check(18'(bus.outputWordRequest), 18'(b));
        end
        singleCycleBreakIn = 1'b0;
        $display("transfer test done");
        countBecameZero = 1'b1;
        tick(3);
        countBecameZero = 1'b0;
        check(18'(transferDone), 18'h00001);
        clearRequest = 1'b1;
        tick(1);
        clearRequest = 1'b0;
        tick(40);
        check(18'(transferDone), 18'h00000);
        {runEnable, wantInterrupt} = 2'b01;
        tick(40);
        check(18'(bus.programInterruptRequest), 18'h00000);
        check(18'(deviceEnabled), 18'h00000);
        $display("clear test done");
        final_report;
    end
    // watchdog: the tests need some 930 cycles
    initial
    begin
        #200000;
        errors++;
        final_report;
    end
endmodule
